// [rtl/lsso_pkg.sv]
/*
 Holds the object indices, status-word bit positions, widths and reset values
 for the load status and set-point object bank.
 Assumes a single 20 MHz clock and a synchronous active-high reset.
*/
package lsso_pkg;
    // Object indices as seen by the fieldbus master
    localparam logic [15:0] IDX_STATUS = 16'h200d;
    localparam logic [15:0] IDX_MEAS_I = 16'h2101;
    localparam logic [15:0] IDX_MEAS_V = 16'h2102;
    localparam logic [15:0] IDX_SETI_WR = 16'h2201;
    localparam logic [15:0] IDX_SETI_RD = 16'h2202;
    localparam logic [15:0] IDX_SETV_WR = 16'h2203;
    localparam logic [15:0] IDX_SETV_RD = 16'h2204;
    localparam int STATUS_W = 64;
    localparam int FLT_W = 32;
    localparam logic [31:0] SETPOINT_RST = 32'h0000_0000;
    // Status word bit positions
    localparam int B_STANDBY = 0;
    localparam int B_LIVE = 1;
    localparam int B_I_SOFT = 4;
    localparam int B_V_SOFT = 5;
    localparam int B_P_SOFT = 6;
    localparam int B_SENSE_OOB = 7;
    localparam int B_V_LOW_SOFT = 8;
    localparam int B_SHUTDOWN = 9;
    localparam int B_LIN_PWR = 10;
    localparam int B_RES_PWR = 11;
    localparam int B_BOOT_FAIL = 12;
    localparam int B_BOOT_PEND = 13;
    localparam int B_PHASE_AMPS = 14;
    localparam int B_COMM = 15;
    localparam int B_AMPS_HARD = 16;
    localparam int B_VOLTS_HARD = 17;
    localparam int B_LIN_HOT = 18;
    localparam int B_FUSE = 19;
    localparam int B_INTERLOCK = 20;
    localparam int B_MAINT = 22;
    localparam int B_DIODE_HOT = 23;
    localparam int B_BAD_SETUP = 24;
    localparam int B_STACK = 25;
    localparam int B_WIRING = 26;
    localparam int B_RES_HOT = 27;
    localparam int B_BELOW_MIN = 28;
    localparam int B_REG_LOST = 29;
    localparam int B_UPGRADE = 30;
    localparam int B_REG_AMPS = 32;
    localparam int B_REG_VOLTS = 33;
    localparam int B_REG_OHMS = 34;
    localparam int B_REG_WATTS = 35;
    localparam int B_EXT_RANGE = 36;
    localparam int B_SENSE_USED = 37;
    localparam int B_LOCK = 38;
    localparam int B_EXT_ANALOG = 39;
    localparam int B_THERMAL = 40;
    localparam int B_SOFT_SHUT = 41;
    localparam int B_HARD_SHUT = 42;
    // Bits that are driven at all; every other bit reads zero
    localparam logic [63:0] STATUS_USED_MASK = 64'h0000_07ff_7fdf_fff3;
    localparam logic [63:0] STATUS_RST = 64'h0000_0000_0000_0000;
endpackage

// [rtl/lsso_cond_if.sv]
/*
 Carries the synchronised condition vector from the object bank to the status assembler.
 Assumes all signals are already synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface lsso_cond_if;
    logic [63:0] cond;
    logic [63:0] word;
    modport src (output cond, input word);
    modport asm (input cond, output word);
endinterface
`default_nettype wire

// [rtl/lsso_status_asm.sv]
/*
 Builds the live 64-bit operation status word from synchronised conditions.
 Assumes conditions are synchronous levels; it holds no state of its own.
*/
`timescale 1ns/1ps
`default_nettype none
module lsso_status_asm (
    lsso_cond_if.asm cif
);
    wire logic thermal_any;
    wire logic [63:0] combined;

    // Linear and resistor stage heat combine; diode heat is reported alone
    assign thermal_any = cif.cond[lsso_pkg::B_LIN_HOT] | cif.cond[lsso_pkg::B_RES_HOT];
    assign combined = cif.cond | ({63'h0, thermal_any} << lsso_pkg::B_THERMAL);
    // Unused bits forced to zero regardless of input
    assign cif.word = combined & lsso_pkg::STATUS_USED_MASK;
endmodule
`default_nettype wire

// [rtl/lsso_object_bank.sv]
/*
 Fieldbus-visible object bank of a DC electronic load: live status word,
 averaged measurements and current/voltage set-points.
 Assumes the fieldbus master presents a one-cycle read or write strobe with an
 object index, and that condition and measurement inputs come from other clock
 domains and are synchronised here.
*/
// Contract
// - Status word is read-only and mirrors present conditions without latching.
// - Reading the status word changes nothing.
// - Questionable flags are a subset of the status word at fixed positions.
// - Bit 0 shows standby, bit 1 shows the load active.
// - Bit 7 shows remote-sense voltage out of bounds.
// - Bit 41 flags shutdown from soft faults in bits 4, 5, 6, 8.
// - Bit 42 flags shutdown from a hard fault.
// - Bit 9 shows a target asserting shutdown.
// - Bits 10 and 11 show linear and resistor power over rating.
// - Bit 12 shows a target failed to boot, bit 13 boot pending.
// - Bit 15 shows corrupted internal communications.
// - Bits 16 and 17 show terminal current and voltage over rating.
// - Bit 40 combines linear (18) and resistor (27) heat; diode heat bit 23.
// - Bit 19 shows the auxiliary supply fuse blown.
// - Bit 24 shows an invalid stored product configuration.
// - Bit 26 shows a user input wiring fault.
// - Bit 29 shows the load out of regulation.
// - Bits 32-35 regulation state, 36 range, 37 sense use, 38 lock.
// - Bit 39 shows external analog control.
// - Measured current is read-only averaged current, 32-bit float.
// - Measured voltage returns sense voltage when remote sensing is engaged and bit 37 shows sense terminals used.
// - Current set-point is read-write float, used in constant-current operation.
`timescale 1ns/1ps
`default_nettype none
module lsso_object_bank (
    input wire logic mclk,
    input wire logic rst,
    // Object access from the fieldbus side
    input wire logic obj_rd,
    input wire logic obj_wr,
    input wire logic [15:0] obj_index,
    input wire logic [31:0] obj_wdata,
    output logic [63:0] obj_rdata,
    output logic obj_rvalid,
    output logic obj_err,
    // Present conditions from the load
    input wire logic standby,
    input wire logic live,
    input wire logic i_high_soft_flag,
    input wire logic v_high_soft_flag,
    input wire logic p_high_soft_flag,
    input wire logic sense_out_of_bounds,
    input wire logic v_low_soft_flag,
    input wire logic target_shutdown,
    input wire logic linear_stage_power_limit,
    input wire logic resistor_stage_power_limit,
    input wire logic target_start_failed,
    input wire logic target_start_pending,
    input wire logic phase_amps_exceeded,
    input wire logic comm_corrupted,
    input wire logic terminal_amps_hard_flag,
    input wire logic terminal_volts_hard_flag,
    input wire logic linear_stage_hot,
    input wire logic aux_supply_fuse_open,
    input wire logic interlock_open,
    input wire logic maintenance_due,
    input wire logic diode_stage_hot,
    input wire logic bad_product_setup,
    input wire logic stack_exceeded,
    input wire logic user_input_wiring_fault,
    input wire logic resistor_stage_hot,
    input wire logic below_min_volts,
    input wire logic regulation_lost,
    input wire logic target_upgrading,
    input wire logic reg_state_amps,
    input wire logic reg_state_volts,
    input wire logic reg_state_ohms,
    input wire logic reg_state_watts,
    input wire logic extended_range_active,
    input wire logic sense_terminals_used,
    input wire logic lock_active,
    input wire logic external_analog_control,
    input wire logic soft_fault_shutdown,
    input wire logic hard_fault_shutdown,
    input wire logic sense_engaged,
    // Averaged measurements, float encoded, updated with a strobe
    input wire logic [31:0] avg_terminal_amps,
    input wire logic [31:0] avg_terminal_volts,
    input wire logic [31:0] avg_sense_volts,
    input wire logic meas_update,
    // Regulation targets toward the control loop
    output logic [31:0] current_setpoint,
    output logic [31:0] voltage_setpoint,
    output logic amps_target_active,
    output logic volts_target_active
);
    logic [63:0] cond_raw;
    logic [63:0] cond_s1_q;
    logic [63:0] cond_s2_q;
    logic [2:0] upd_s1_q;
    logic [2:0] upd_s2_q;
    logic [31:0] meas_i_q;
    logic [31:0] meas_v_q;
    logic [31:0] seti_q;
    logic [31:0] setv_q;
    logic [63:0] rdata_d;
    logic [63:0] rdata_q;
    logic rvalid_q;
    logic err_q;
    wire logic hit_status;
    wire logic hit_meas_i;
    wire logic hit_meas_v;
    wire logic hit_seti_wr;
    wire logic hit_seti_rd;
    wire logic hit_setv_wr;
    wire logic hit_setv_rd;
    wire logic rd_known;
    wire logic wr_known;
    wire logic upd_edge;
    wire logic sense_sel;
    wire logic [31:0] volts_src;
    lsso_cond_if cif ();

    always_comb begin
        cond_raw = '0;
        cond_raw[lsso_pkg::B_STANDBY] = standby;
        cond_raw[lsso_pkg::B_LIVE] = live;
        cond_raw[lsso_pkg::B_I_SOFT] = i_high_soft_flag;
        cond_raw[lsso_pkg::B_V_SOFT] = v_high_soft_flag;
        cond_raw[lsso_pkg::B_P_SOFT] = p_high_soft_flag;
        cond_raw[lsso_pkg::B_SENSE_OOB] = sense_out_of_bounds;
        cond_raw[lsso_pkg::B_V_LOW_SOFT] = v_low_soft_flag;
        cond_raw[lsso_pkg::B_SHUTDOWN] = target_shutdown;
        cond_raw[lsso_pkg::B_LIN_PWR] = linear_stage_power_limit;
        cond_raw[lsso_pkg::B_RES_PWR] = resistor_stage_power_limit;
        cond_raw[lsso_pkg::B_BOOT_FAIL] = target_start_failed;
        cond_raw[lsso_pkg::B_BOOT_PEND] = target_start_pending;
        cond_raw[lsso_pkg::B_PHASE_AMPS] = phase_amps_exceeded;
        cond_raw[lsso_pkg::B_COMM] = comm_corrupted;
        cond_raw[lsso_pkg::B_AMPS_HARD] = terminal_amps_hard_flag;
        cond_raw[lsso_pkg::B_VOLTS_HARD] = terminal_volts_hard_flag;
        cond_raw[lsso_pkg::B_LIN_HOT] = linear_stage_hot;
        cond_raw[lsso_pkg::B_FUSE] = aux_supply_fuse_open;
        cond_raw[lsso_pkg::B_INTERLOCK] = interlock_open;
        cond_raw[lsso_pkg::B_MAINT] = maintenance_due;
        cond_raw[lsso_pkg::B_DIODE_HOT] = diode_stage_hot;
        cond_raw[lsso_pkg::B_BAD_SETUP] = bad_product_setup;
        cond_raw[lsso_pkg::B_STACK] = stack_exceeded;
        cond_raw[lsso_pkg::B_WIRING] = user_input_wiring_fault;
        cond_raw[lsso_pkg::B_RES_HOT] = resistor_stage_hot;
        cond_raw[lsso_pkg::B_BELOW_MIN] = below_min_volts;
        cond_raw[lsso_pkg::B_REG_LOST] = regulation_lost;
        cond_raw[lsso_pkg::B_UPGRADE] = target_upgrading;
        cond_raw[lsso_pkg::B_REG_AMPS] = reg_state_amps;
        cond_raw[lsso_pkg::B_REG_VOLTS] = reg_state_volts;
        cond_raw[lsso_pkg::B_REG_OHMS] = reg_state_ohms;
        cond_raw[lsso_pkg::B_REG_WATTS] = reg_state_watts;
        cond_raw[lsso_pkg::B_EXT_RANGE] = extended_range_active;
        cond_raw[lsso_pkg::B_SENSE_USED] = sense_terminals_used;
        cond_raw[lsso_pkg::B_LOCK] = lock_active;
        cond_raw[lsso_pkg::B_EXT_ANALOG] = external_analog_control;
        cond_raw[lsso_pkg::B_SOFT_SHUT] = soft_fault_shutdown;
        cond_raw[lsso_pkg::B_HARD_SHUT] = hard_fault_shutdown;
        // Engage flag rides in an unused slot; the assembler masks it out
        cond_raw[63] = sense_engaged;
    end

    // Two-stage synchronisers; conditions are levels from other domains
    always_ff @(posedge mclk) begin
        if (rst) begin
            cond_s1_q <= lsso_pkg::STATUS_RST;
            cond_s2_q <= lsso_pkg::STATUS_RST;
        end else begin
            cond_s1_q <= cond_raw;
            cond_s2_q <= cond_s1_q;
        end
    end

    assign cif.cond = cond_s2_q;

    lsso_status_asm u_asm (
        .cif(cif.asm)
    );

    // Measurement words are caught on a synchronised update strobe, so a word
    // is never sampled while it changes; data is held stable around the strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            upd_s1_q <= 3'h0;
            upd_s2_q <= 3'h0;
        end else begin
            upd_s1_q <= {upd_s1_q[1:0], meas_update};
            upd_s2_q <= {upd_s2_q[1:0], upd_s1_q[2]};
        end
    end

    assign upd_edge = upd_s2_q[1] & ~upd_s2_q[2];
    assign sense_sel = cond_s2_q[63] & cond_s2_q[lsso_pkg::B_SENSE_USED];
    assign volts_src = sense_sel ? avg_sense_volts : avg_terminal_volts;

    always_ff @(posedge mclk) begin
        if (rst) begin
            meas_i_q <= 32'h0000_0000;
            meas_v_q <= 32'h0000_0000;
        end else if (upd_edge) begin
            meas_i_q <= avg_terminal_amps;
            meas_v_q <= volts_src;
        end
    end

    assign hit_status = obj_index == lsso_pkg::IDX_STATUS;
    assign hit_meas_i = obj_index == lsso_pkg::IDX_MEAS_I;
    assign hit_meas_v = obj_index == lsso_pkg::IDX_MEAS_V;
    assign hit_seti_wr = obj_index == lsso_pkg::IDX_SETI_WR;
    assign hit_seti_rd = obj_index == lsso_pkg::IDX_SETI_RD;
    assign hit_setv_wr = obj_index == lsso_pkg::IDX_SETV_WR;
    assign hit_setv_rd = obj_index == lsso_pkg::IDX_SETV_RD;
    assign rd_known = hit_status | hit_meas_i | hit_meas_v | hit_seti_rd | hit_setv_rd;
    // Read-only objects have no write index, so writes to them are refused
    assign wr_known = hit_seti_wr | hit_setv_wr;

    // Set-points: written only through their write index
    always_ff @(posedge mclk) begin
        if (rst) begin
            seti_q <= lsso_pkg::SETPOINT_RST;
            setv_q <= lsso_pkg::SETPOINT_RST;
        end else if (obj_wr) begin
            if (hit_seti_wr) begin
                seti_q <= obj_wdata;
            end
            if (hit_setv_wr) begin
                setv_q <= obj_wdata;
            end
        end
    end

    // Read mux: purely a selection, so reading disturbs no state
    always_comb begin
        rdata_d = 64'h0;
        if (hit_status) begin
            rdata_d = cif.word;
        end else if (hit_meas_i) begin
            rdata_d = {32'h0, meas_i_q};
        end else if (hit_meas_v) begin
            rdata_d = {32'h0, meas_v_q};
        end else if (hit_seti_rd) begin
            rdata_d = {32'h0, seti_q};
        end else if (hit_setv_rd) begin
            rdata_d = {32'h0, setv_q};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= 64'h0;
            rvalid_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            rvalid_q <= obj_rd & rd_known;
            err_q <= (obj_rd & ~rd_known) | (obj_wr & ~wr_known);
            if (obj_rd) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign obj_rdata = rdata_q;
    assign obj_rvalid = rvalid_q;
    assign obj_err = err_q;
    assign current_setpoint = seti_q;
    assign voltage_setpoint = setv_q;
    // Targets are applied only in the matching regulation state
    assign amps_target_active = cond_s2_q[lsso_pkg::B_REG_AMPS];
    assign volts_target_active = cond_s2_q[lsso_pkg::B_REG_VOLTS];
endmodule
`default_nettype wire

// [verif/lsso_bank_assertions.sv]
/*
 Checker for the object bank: answers, refusals, set-points, status layout.
 Bound to lsso_object_bank and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module lsso_bank_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic obj_rd,
    input wire logic obj_wr,
    input wire logic [15:0] obj_index,
    input wire logic [31:0] obj_wdata,
    input wire logic [63:0] obj_rdata,
    input wire logic obj_rvalid,
    input wire logic obj_err,
    input wire logic [31:0] current_setpoint,
    input wire logic [31:0] voltage_setpoint
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire rd_ok = obj_index inside {lsso_pkg::IDX_STATUS, lsso_pkg::IDX_MEAS_I, lsso_pkg::IDX_MEAS_V,
        lsso_pkg::IDX_SETI_RD, lsso_pkg::IDX_SETV_RD};
    wire wr_i = obj_wr && obj_index == lsso_pkg::IDX_SETI_WR;
    wire wr_v = obj_wr && obj_index == lsso_pkg::IDX_SETV_WR;
    wire bad = (obj_rd && !rd_ok) || (obj_wr && !wr_i && !wr_v);
    wire rd_st = obj_rd && obj_index == lsso_pkg::IDX_STATUS;
    read_answer_a: assert property (1'b1 |=> obj_rvalid == $past(obj_rd && rd_ok))
        else $error("read answer missing or spurious");
    refused_req_a: assert property (1'b1 |=> obj_err == $past(bad))
        else $error("error pulse wrong");
    seti_write_a: assert property (wr_i |=> current_setpoint == $past(obj_wdata))
        else $error("current set-point not written");
    setv_write_a: assert property (wr_v |=> voltage_setpoint == $past(obj_wdata))
        else $error("voltage set-point not written");
    seti_keep_a: assert property (!wr_i |=> $stable(current_setpoint))
        else $error("current set-point changed");
    setv_keep_a: assert property (!wr_v |=> $stable(voltage_setpoint))
        else $error("voltage set-point changed");
    seti_read_a: assert property (obj_rd && !obj_wr && obj_index == lsso_pkg::IDX_SETI_RD
        |=> obj_rdata == {32'h0, $past(current_setpoint)}) else $error("set-point read wrong");
    spare_zero_a: assert property (rd_st |=> (obj_rdata & 64'hffff_f800_8020_000c) == 64'h0)
        else $error("spare status bit set");
    thermal_or_a: assert property (rd_st |=> obj_rdata[40] == (obj_rdata[18] | obj_rdata[27]))
        else $error("combined thermal bit wrong");
    rdata_hold_a: assert property (!obj_rd |=> $stable(obj_rdata))
        else $error("read data moved without a read");
endmodule
bind lsso_object_bank lsso_bank_chk u_chk (.mclk(mclk), .rst(rst), .obj_rd(obj_rd), .obj_wr(obj_wr),
    .obj_index(obj_index), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_rvalid(obj_rvalid),
    .obj_err(obj_err), .current_setpoint(current_setpoint), .voltage_setpoint(voltage_setpoint));
`default_nettype wire

// [verif/lsso_master_model.sv]
/*
 Fieldbus master model: one-cycle read or write requests to the object bank.
 Assumes the bank answers on the taking edge itself and never stalls.
*/
`timescale 1ns/1ps
`default_nettype none
module lsso_master_model (
    input wire logic mclk,
    output logic obj_rd,
    output logic obj_wr,
    output logic [15:0] obj_index,
    output logic [31:0] obj_wdata,
    input wire logic [63:0] obj_rdata,
    input wire logic obj_rvalid,
    input wire logic obj_err
);
    initial begin
        obj_rd = 1'b0;
        obj_wr = 1'b0;
        obj_index = 16'h0;
        obj_wdata = 32'h0;
    end
    // Index and data swing to their inverse once taken, so a stale value cannot pass
    task automatic access(input logic wr, input logic [15:0] idx, input logic [31:0] d,
        output logic [63:0] q, output logic e);
        @(posedge mclk);
        obj_rd <= !wr;
        obj_wr <= wr;
        obj_index <= idx;
        obj_wdata <= d;
        @(posedge mclk);
        obj_rd <= 1'b0;
        obj_wr <= 1'b0;
        obj_index <= ~idx;
        obj_wdata <= ~d;
        @(negedge mclk);
        q = obj_rvalid ? obj_rdata : 64'hx;
        e = obj_err;
    endtask
endmodule
`default_nettype wire

// [verif/test_load_status_and_setpoint_objects.sv]
/*
 Self-checking bench for the object bank, driven through the master model.
 Assumes the design package is compiled first and the checker is bound.
*/
`timescale 1ns/1ps
`default_nettype none
module test_load_status_and_setpoint_objects;
    localparam logic [63:0] SPARE = 64'hffff_f800_8020_000c;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [63:0] c = 64'h0;
    logic [31:0] amps = 32'h0, volts = 32'h0, sense = 32'h0;
    logic upd = 1'b0;
    logic [63:0] q, ex;
    logic e;
    int n_fail = 0, n_checks = 0, cyc = 0;
    wire logic obj_rd, obj_wr, obj_rvalid, obj_err, act_i, act_v;
    wire logic [15:0] obj_index;
    wire logic [31:0] obj_wdata, sp_i, sp_v;
    wire logic [63:0] obj_rdata;
    always #25 mclk = ~mclk;
    lsso_master_model m (.mclk, .obj_rd, .obj_wr, .obj_index, .obj_wdata, .obj_rdata, .obj_rvalid, .obj_err);
    lsso_object_bank DUT (.mclk, .rst, .obj_rd, .obj_wr, .obj_index, .obj_wdata, .obj_rdata, .obj_rvalid,
        .obj_err, .standby(c[0]), .live(c[1]), .i_high_soft_flag(c[4]), .v_high_soft_flag(c[5]),
        .p_high_soft_flag(c[6]), .sense_out_of_bounds(c[7]), .v_low_soft_flag(c[8]), .target_shutdown(c[9]),
        .linear_stage_power_limit(c[10]), .resistor_stage_power_limit(c[11]), .target_start_failed(c[12]),
        .target_start_pending(c[13]), .phase_amps_exceeded(c[14]), .comm_corrupted(c[15]),
        .terminal_amps_hard_flag(c[16]), .terminal_volts_hard_flag(c[17]), .linear_stage_hot(c[18]),
        .aux_supply_fuse_open(c[19]), .interlock_open(c[20]), .maintenance_due(c[22]), .diode_stage_hot(c[23]),
        .bad_product_setup(c[24]), .stack_exceeded(c[25]), .user_input_wiring_fault(c[26]),
        .resistor_stage_hot(c[27]), .below_min_volts(c[28]), .regulation_lost(c[29]), .target_upgrading(c[30]),
        .reg_state_amps(c[32]), .reg_state_volts(c[33]), .reg_state_ohms(c[34]), .reg_state_watts(c[35]),
        .extended_range_active(c[36]), .sense_terminals_used(c[37]), .lock_active(c[38]),
        .external_analog_control(c[39]), .soft_fault_shutdown(c[41]), .hard_fault_shutdown(c[42]),
        .sense_engaged(c[2]), .avg_terminal_amps(amps), .avg_terminal_volts(volts), .avg_sense_volts(sense),
        .meas_update(upd), .current_setpoint(sp_i), .voltage_setpoint(sp_v), .amps_target_active(act_i),
        .volts_target_active(act_v));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // A refused read expects all-x data, meaning no valid pulse came
    task automatic rdx(input logic [15:0] idx, input logic [63:0] exp, input logic eexp);
        m.access(1'b0, idx, 32'h0, q, e);
        chk(q, exp);
        chk({63'h0, e}, {63'h0, eexp});
    endtask
    task automatic wrx(input logic [15:0] idx, input logic [31:0] d, input logic eexp);
        m.access(1'b1, idx, d, q, e);
        chk({63'h0, e}, {63'h0, eexp});
    endtask
    // Conditions pass two synchronising flops before they show
    task automatic put(input logic [63:0] v);
        @(posedge mclk);
        c <= v;
        repeat (3) @(posedge mclk);
    endtask
    // Measurement words settle first; the strobe is held long enough to cross
    // the synchroniser, then dropped long enough for the next rise to be seen
    task automatic meas(input logic [31:0] a, input logic [31:0] v, input logic [31:0] s);
        @(posedge mclk);
        amps <= a;
        volts <= v;
        sense <= s;
        @(posedge mclk);
        upd <= 1'b1;
        repeat (8) @(posedge mclk);
        upd <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
    task automatic close_out;
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            close_out;
        end
    end
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rdx(lsso_pkg::IDX_STATUS, 64'h0, 1'b0);
        rdx(lsso_pkg::IDX_MEAS_V, 64'h0, 1'b0);
        for (int i = 0; i < 64; i++) begin
            put(64'h1 << i);
            ex = (64'h1 << i) & ~SPARE & ~(64'h1 << 40);
            ex[40] = ex[18] | ex[27];
            rdx(lsso_pkg::IDX_STATUS, ex, 1'b0);
            rdx(lsso_pkg::IDX_STATUS, ex, 1'b0);
            chk({62'h0, act_v, act_i}, {62'h0, ex[33], ex[32]});
        end
        put(64'hffff_ffff_ffff_ffff);
        rdx(lsso_pkg::IDX_STATUS, 64'h0000_07ff_7fdf_fff3, 1'b0);
        put(64'h0);
        rdx(lsso_pkg::IDX_STATUS, 64'h0, 1'b0);
        meas(32'h3fc0_0000, 32'h4120_0000, 32'h411c_0000);
        rdx(lsso_pkg::IDX_MEAS_I, 64'h3fc0_0000, 1'b0);
        rdx(lsso_pkg::IDX_MEAS_V, 64'h4120_0000, 1'b0);
        put(64'h1 << 37);
        meas(32'h3fc0_0000, 32'h4130_0000, 32'h411c_0000);
        rdx(lsso_pkg::IDX_MEAS_V, 64'h4130_0000, 1'b0);
        put(64'h4);
        meas(32'h3fc0_0000, 32'h4140_0000, 32'h411c_0000);
        rdx(lsso_pkg::IDX_MEAS_V, 64'h4140_0000, 1'b0);
        put(64'h20_0000_0004);
        meas(32'h3fc8_0000, 32'h4140_0000, 32'h411c_0000);
        rdx(lsso_pkg::IDX_MEAS_V, 64'h411c_0000, 1'b0);
        rdx(lsso_pkg::IDX_MEAS_I, 64'h3fc8_0000, 1'b0);
        wrx(lsso_pkg::IDX_SETI_WR, 32'h4049_0fdb, 1'b0);
        wrx(lsso_pkg::IDX_SETV_WR, 32'hc2f6_e979, 1'b0);
        rdx(lsso_pkg::IDX_SETI_RD, 64'h4049_0fdb, 1'b0);
        rdx(lsso_pkg::IDX_SETV_RD, 64'hc2f6_e979, 1'b0);
        chk({sp_v, sp_i}, 64'hc2f6_e979_4049_0fdb);
        wrx(lsso_pkg::IDX_STATUS, 32'hffff_ffff, 1'b1);
        wrx(lsso_pkg::IDX_MEAS_I, 32'h1, 1'b1);
        wrx(lsso_pkg::IDX_SETI_RD, 32'h0, 1'b1);
        rdx(lsso_pkg::IDX_SETI_WR, 64'hx, 1'b1);
        rdx(16'h2103, 64'hx, 1'b1);
        rdx(lsso_pkg::IDX_SETI_RD, 64'h4049_0fdb, 1'b0);
        rdx(lsso_pkg::IDX_STATUS, 64'h20_0000_0000, 1'b0);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rdx(lsso_pkg::IDX_SETV_RD, 64'h0, 1'b0);
        rdx(lsso_pkg::IDX_MEAS_I, 64'h0, 1'b0);
        close_out;
    end
endmodule
`default_nettype wire
